// File: verilog/rung_eval_regs.vh
// Operation
// - rung logic lives on an eight-deep push-down stack; pushes shift entries down
// - a push beyond eight levels raises an error instead of evaluating
// - or-merge ORs the top two levels into one
// - and-merge ANDs the top two levels into one
// - push contact pushes the addressed bit uninverted
// - push inverted contact pushes the complement of the addressed bit
// - or contact ORs the addressed image bit into the top
// - or inverted contact ORs the complemented image bit into the top
// - compare two 4-digit values for equal, unequal, greater-or-equal, less-than
// - physical inputs sampled and outputs driven only in update phases, except by immediate contacts and coils
// - immediate contact and coil access physical points, pausing execution meanwhile
// - an immediate read never writes the input image
// - later plain instructions use the image; later immediates sample again
// - an immediate output drives the physical point and updates the output image
`ifndef RUNG_EVAL_REGS_VH
`define RUNG_EVAL_REGS_VH
`define OP_NOP 4'h0
`define OP_PUSH 4'h1
`define OP_PUSH_INV 4'h2
`define OP_OR 4'h3
`define OP_OR_INV 4'h4
`define OP_OR_MERGE 4'h5
`define OP_AND_MERGE 4'h6
`define OP_PUSH_CMP 4'h7
`define OP_PUSH_IMM 4'h8
`define OP_PUSH_INV_IMM 4'h9
`define OP_OUT_IMM 4'ha
`define OP_OUT 4'hb
`define CMP_EQ 2'h0
`define CMP_NE 2'h1
`define CMP_GE 2'h2
`define CMP_LT 2'h3
`define STACK_DEPTH 8
`define IMM_WAIT 4'h3
`endif

// File: verilog/bool_stack.v
`timescale 1ns/1ns
`include "rung_eval_regs.vh"
// eight-entry shift stack; each level is a register
module bool_stack #(
	parameter DEPTH = `STACK_DEPTH
) (
	input wire sys_clk,
	input wire rst,
	input wire ce,
	input wire clear,
	input wire push,
	input wire pushBit,
	input wire merge,
	input wire mergeIsAnd,
	input wire orTop,
	input wire orBit,
	output wire top
);
	reg [DEPTH-1:0] level;
	genvar i;
	assign top = level[0];
	// level 0 is the top; a merge pulls the rest up one level
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_lvl
			always @(posedge sys_clk) begin
				if (rst || (ce && clear)) begin
					level[i] <= 1'b0;
				end else if (ce) begin
					if (push) begin
						level[i] <= (i == 0) ? pushBit : level[(i == 0) ? 0 : i-1];
					end else if (merge) begin
						if (i == 0)
							level[i] <= mergeIsAnd ? (level[0] & level[1 % DEPTH]) :
								(level[0] | level[1 % DEPTH]);
						else
							level[i] <= (i == DEPTH-1) ? 1'b0 : level[(i + 1) % DEPTH];
					end else if (orTop && i == 0) begin
						level[i] <= level[0] | orBit;
					end
				end
			end
		end
	endgenerate
endmodule // bool_stack

// File: verilog/rung_evaluator.v
`timescale 1ns/1ns
`include "rung_eval_regs.vh"
module rung_evaluator #(
	parameter NIN = 8,
	parameter NOUT = 8,
	parameter AW = 3,
	parameter DW = 16
) (
	input wire sys_clk,
	input wire rst,
	input wire ce,
	input wire rungStart,
	input wire instValid,
	input wire [3:0] opcode,
	input wire [AW-1:0] bitAddr,
	input wire useMemBit,
	input wire memBit,
	input wire [1:0] cmpSel,
	input wire [DW-1:0] cmpA,
	input wire [DW-1:0] cmpB,
	input wire inputPhase,
	input wire outputPhase,
	input wire [NIN-1:0] physIn,
	output wire instReady,
	output reg [NOUT-1:0] physOut,
	output reg [NIN-1:0] inImage,
	output reg [NOUT-1:0] outImage,
	output wire rungResult,
	output reg [3:0] depth,
	output reg stackError
);
	// two-flop pin sync and the immediate access sequencer state
	reg [NIN-1:0] inSync1;
	reg [NIN-1:0] inSync2;
	reg [3:0] waitCnt;
	reg busy;
	reg [3:0] busyOp;
	reg [AW-1:0] busyAddr;
	reg cmpRes;
	reg imageBit;

	// decodes and strobes; the strobes are qualified by accept or by the end of a pause, the opcode decodes are not
	wire topBit;
	wire accept;
	wire isPush;
	wire isMerge;
	wire immDone;
	wire stackPush;
	wire stackPushBit;
	wire immBit;
	wire isImm;
	wire isOrContact;
	wire orGo;
	wire orBit;
	wire mergeGo;
	wire immPushDone;
	wire outImmDone;
	wire pushReq;

	// physical inputs pass two flops before use
	// an immediate read takes the second flop too, one more cycle traded for safety
	always @(posedge sys_clk) begin
		if (rst) begin
			inSync1 <= {NIN{1'b0}};
			inSync2 <= {NIN{1'b0}};
		end else if (ce) begin
			inSync1 <= physIn;
			inSync2 <= inSync1;
		end
	end

	// comparison contact on two 4-digit words, unsigned like bcd digits
	// the last select code falls to less-than so every path assigns the result
	always @* begin
		case (cmpSel)
			`CMP_EQ: cmpRes = (cmpA == cmpB);
			`CMP_NE: cmpRes = (cmpA != cmpB);
			`CMP_GE: cmpRes = (cmpA >= cmpB);
			default: cmpRes = (cmpA < cmpB);
		endcase
	end

	// contact source: image bit or a memory bit
	always @* begin
		if (useMemBit)
			imageBit = memBit;
		else
			imageBit = inImage[bitAddr];
	end

	// immediate ops stall the sequencer; no new instruction while busy
	assign instReady = !busy;
	assign accept = ce && instValid && !busy;
	assign isPush = (opcode == `OP_PUSH) || (opcode == `OP_PUSH_INV) ||
		(opcode == `OP_PUSH_CMP);
	assign isMerge = (opcode == `OP_OR_MERGE) || (opcode == `OP_AND_MERGE);
	assign immDone = busy && (waitCnt == 4'h0);
	// immediate opcodes go through the stall sequencer, not the plain stack path
	assign isImm = (opcode == `OP_PUSH_IMM) || (opcode == `OP_PUSH_INV_IMM) ||
		(opcode == `OP_OUT_IMM);
	// parallel contact; a rung start in the same cycle wins
	assign isOrContact = (opcode == `OP_OR) || (opcode == `OP_OR_INV);
	assign orGo = accept && isOrContact && !rungStart;
	assign orBit = (opcode == `OP_OR_INV) ? ~imageBit : imageBit;
	// a merge below two levels has nothing to combine and is dropped
	assign mergeGo = accept && isMerge && (depth > 4'h1) && !rungStart;
	// end of a pause: either the pushing read or the output write lands now
	assign immPushDone = immDone && (busyOp != `OP_OUT_IMM);
	assign outImmDone = immDone && (busyOp == `OP_OUT_IMM);
	// any request for a new level, whether or not it still fits
	assign pushReq = (accept && isPush) || immPushDone;
	// the freshly sampled pin feeds only this push, never the image
	assign immBit = inSync2[busyAddr];
	// overflow push is refused so the stack is left as it was; after an
	// overflow the rung is void, so pushes stay refused until the next start
	assign stackPush = pushReq && (depth < `STACK_DEPTH) && !stackError;

	// choose what the push places on top
	assign stackPushBit = immDone ? ((busyOp == `OP_PUSH_INV_IMM) ? ~immBit : immBit) :
		(opcode == `OP_PUSH_CMP) ? cmpRes :
		(opcode == `OP_PUSH_INV) ? ~imageBit : imageBit;

	// the stack holds only bits; depth and the overflow flag are kept here
	bool_stack #(
		.DEPTH(`STACK_DEPTH)
	) u_stack (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.clear(rungStart),
		.push(stackPush),
		.pushBit(stackPushBit),
		.merge(mergeGo),
		.mergeIsAnd(opcode == `OP_AND_MERGE),
		.orTop(orGo),
		.orBit(orBit),
		.top(topBit)
	);
	// rung result is the stack top straight from its flop
	assign rungResult = topBit;

	// stack depth; a rung start clears it and wins over an instruction that cycle
	always @(posedge sys_clk) begin
		if (rst) begin
			depth <= 4'h0;
		end else if (ce) begin
			if (rungStart)
				depth <= 4'h0;
			else if (stackPush)
				depth <= depth + 4'h1;
			else if (mergeGo)
				depth <= depth - 4'h1;
		end
	end

	// overflow flag: set by a refused push, held until a rung start so the rung
	// is reported void rather than evaluated with a lost level
	always @(posedge sys_clk) begin
		if (rst) begin
			stackError <= 1'b0;
		end else if (ce) begin
			if (rungStart)
				stackError <= 1'b0;
			else if (pushReq && !stackPush)
				stackError <= 1'b1;
		end
	end

	// immediate access sequencer: holds off execution for IMM_WAIT plus one cycles
	// the count stands for the pin access time; the sequencer drives instReady low meanwhile
	always @(posedge sys_clk) begin
		if (rst) begin
			busy <= 1'b0;
			waitCnt <= 4'h0;
			busyOp <= `OP_NOP;
			busyAddr <= {AW{1'b0}};
		end else if (ce) begin
			if (accept && isImm) begin
				busy <= 1'b1;
				waitCnt <= `IMM_WAIT;
				busyOp <= opcode;
				busyAddr <= bitAddr;
			end else if (immDone) begin
				busy <= 1'b0;
			end else if (busy) begin
				waitCnt <= waitCnt - 4'h1;
			end
		end
	end

	// input image loads only in the input update phase
	// an immediate read never lands here, so later plain contacts keep the old image
	always @(posedge sys_clk) begin
		if (rst) begin
			inImage <= {NIN{1'b0}};
		end else if (ce && inputPhase) begin
			inImage <= inSync2;
		end
	end

	// output image: a plain coil writes only here; an immediate write lands here too
	always @(posedge sys_clk) begin
		if (rst) begin
			outImage <= {NOUT{1'b0}};
		end else if (ce) begin
			if (accept && (opcode == `OP_OUT))
				outImage[bitAddr] <= topBit;
			else if (outImmDone)
				outImage[busyAddr] <= topBit;
		end
	end

	// pins follow the image only in the output phase; an immediate write that
	// lands in that cycle takes it, and the other points wait for the next phase
	always @(posedge sys_clk) begin
		if (rst) begin
			physOut <= {NOUT{1'b0}};
		end else if (ce) begin
			if (outImmDone)
				physOut[busyAddr] <= topBit;
			else if (outputPhase)
				physOut <= outImage;
		end
	end
endmodule // rung_evaluator

// File: test/field_pins.sv
`timescale 1ns/1ns
// field input points: a new level lands just after an edge, never aligned to the syncer
module field_pins (
	input wire sys_clk,
	input wire [7:0] level,
	output reg [7:0] physIn
);
	// pins follow the requested level one edge later
	always @(posedge sys_clk) physIn <= #1 level;
endmodule // field_pins

// File: test/rung_eval_asserts.sv
`timescale 1ns/1ns
module rung_eval_asserts (
	input wire sys_clk,
	input wire rst,
	input wire ce,
	input wire rungStart,
	input wire instValid,
	input wire [3:0] opcode,
	input wire [2:0] bitAddr,
	input wire useMemBit,
	input wire inputPhase,
	input wire instReady,
	input wire [7:0] inImage,
	input wire rungResult,
	input wire [3:0] depth,
	input wire stackError
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// an accepted instruction; rungStart wins so it is left out
	wire tk = ce && instValid && instReady && !rungStart;
	wire b = !useMemBit && inImage[bitAddr];
	// a push only lands while there is room and no overflow is pending
	wire room = (depth < 4'h8) && !stackError;
	wire mrg = (opcode == 4'h5) || (opcode == 4'h6);
	sequence busyWin; !instReady ##[1:6] instReady; endsequence
	a_start_clears: assert property (ce && rungStart |=> depth == 4'h0 && !stackError)
		else $error("start left state");
	a_push_grows: assert property (tk && opcode == 4'h1 && room
		|=> depth == $past(depth) + 4'h1) else $error("push depth");
	a_push_value: assert property (tk && opcode == 4'h1 && room && !useMemBit
		|=> rungResult == $past(b)) else $error("push value");
	a_pushn_value: assert property (tk && opcode == 4'h2 && room && !useMemBit
		|=> rungResult == !$past(b)) else $error("inverted push value");
	a_overflow_flag: assert property (tk && opcode == 4'h1 && depth == 4'h8
		|=> stackError && depth == 4'h8) else $error("no overflow");
	a_merge_drops: assert property (tk && mrg && depth > 4'h1
		|=> depth == $past(depth) - 4'h1) else $error("merge depth");
	a_or_sets: assert property (tk && opcode == 4'h3 && depth != 4'h0 && b
		|=> rungResult) else $error("or contact");
	a_orn_sets: assert property (tk && opcode == 4'h4 && depth != 4'h0 && !useMemBit && !b
		|=> rungResult) else $error("inverted or contact");
	a_imm_pause: assert property (tk && opcode == 4'h8 |=> busyWin)
		else $error("no pause");
	a_imm_image: assert property (tk && opcode[3:1] == 3'h4 && !inputPhase
		|=> $stable(inImage)) else $error("image touched");
endmodule // rung_eval_asserts
bind rung_evaluator rung_eval_asserts rung_eval_asserts_i (.sys_clk(sys_clk), .rst(rst),
	.ce(ce), .rungStart(rungStart), .instValid(instValid), .opcode(opcode), .bitAddr(bitAddr),
	.useMemBit(useMemBit), .inputPhase(inputPhase), .instReady(instReady),
	.inImage(inImage), .rungResult(rungResult), .depth(depth), .stackError(stackError));

// File: test/test_rung_evaluator.sv
`timescale 1ns/1ns
module test_rung_evaluator;
	reg sys_clk = 0, rst = 1, ce = 1, rungStart = 0, instValid = 0, useMemBit = 0, memBit = 0;
	reg inputPhase = 0, outputPhase = 0, er = 0, c;
	reg [3:0] opcode = 4'h0, dp = 4'h0, o;
	reg [2:0] bitAddr = 3'h0;
	reg [1:0] cmpSel = 2'h0;
	reg [15:0] cmpA = 16'h0000, cmpB = 16'h0000;
	reg [7:0] lvl = 8'h00, img, st = 8'h00;
	reg [5:0] q[$];
	wire [7:0] physIn, physOut, inImage, outImage;
	wire [3:0] depth;
	wire instReady, rungResult, stackError;
	integer miscompares = 0, n_checks = 0, i;
	field_pins field_pins_i (.sys_clk(sys_clk), .level(lvl), .physIn(physIn));
	rung_evaluator rung_evaluator_i (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.rungStart(rungStart), .instValid(instValid), .opcode(opcode), .bitAddr(bitAddr),
		.useMemBit(useMemBit), .memBit(memBit), .cmpSel(cmpSel), .cmpA(cmpA), .cmpB(cmpB),
		.inputPhase(inputPhase), .outputPhase(outputPhase), .physIn(physIn),
		.instReady(instReady), .physOut(physOut), .inImage(inImage), .outImage(outImage),
		.rungResult(rungResult), .depth(depth), .stackError(stackError));
	task chk(input [7:0] s, input [7:0] e); begin
		n_checks = n_checks + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("BAD %0t saw %h want %h", $time, s, e);
		end
	end endtask
	task close_out; begin
		if (miscompares == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end endtask
	// reference stack first, then one instruction; v is the contact value it should see
	task op(input [3:0] k, input v); begin
		if (k < 4'h3 || k == 4'h7 || k[3:1] == 3'h4) begin
			if (dp == 4'h8 || er) er = 1;
			else begin st = {st[6:0], v}; dp = dp + 4'h1; end
		end else if (k < 4'h5) st[0] = st[0] | v;
		else if (k < 4'h7 && dp > 4'h1) begin
			st = {1'b0, st[7:2], (k == 4'h5) ? st[1] | st[0] : st[1] & st[0]};
			dp = dp - 4'h1;
		end
		q.push_back({er, dp, st[0]});
		@(posedge sys_clk); #1 opcode = k; instValid = 1;
		@(posedge sys_clk); #1 instValid = 0;
		while (instReady !== 1'b1) begin @(posedge sys_clk); #1; end
	end endtask
	task rs; begin
		@(posedge sys_clk); #1 rungStart = 1;
		@(posedge sys_clk); #1 rungStart = 0;
		st = 0; dp = 0; er = 0;
		chk({stackError, depth}, 8'h00);
	end endtask
	// watcher: the oldest expectation is due once the instruction has finished
	always @(posedge sys_clk) if (ce && instValid && instReady && !rst) begin
		#1;
		while (instReady !== 1'b1) begin @(posedge sys_clk); #1; end
		chk({stackError, depth, rungResult}, q.pop_front());
	end
	// 100 ns clock
	initial begin forever #50 sys_clk = ~sys_clk; end
	// a hang counts as a failure
	initial begin #1000000; miscompares = miscompares + 1; close_out; end
	initial begin
		void'($urandom(22668));
		repeat (12) @(posedge sys_clk);
		#1 rst = 0;
		chk({instReady, stackError, depth, rungResult} | physOut | inImage | outImage, 8'h40);
		img = $urandom; lvl = img;
		repeat (4) @(posedge sys_clk);
		#1 chk(inImage, 8'h00);
		inputPhase = 1;
		@(posedge sys_clk); #1 inputPhase = 0;
		@(posedge sys_clk); #1 chk(inImage, img);
		rs;
		for (i = 0; i < 40; i = i + 1) begin
			bitAddr = $urandom; useMemBit = $urandom; memBit = $urandom;
			o = 4'h1 + $urandom % 6;
			if (dp == 4'h0) o = 4'h1 + o[0];
			op(o, (useMemBit ? memBit : img[bitAddr]) ^ (o == 4'h2 || o == 4'h4));
		end
		useMemBit = 0;
		rs;
		for (i = 0; i < 9; i = i + 1) op(4'h1, img[bitAddr]);
		rs;
		for (i = 0; i < 8; i = i + 1) begin
			cmpSel = i; cmpA = $urandom; cmpB = i[2] ? cmpA : $urandom;
			c = cmpSel == 0 ? cmpA == cmpB : cmpSel == 1 ? cmpA != cmpB :
				cmpSel == 2 ? cmpA >= cmpB : cmpA < cmpB;
			op(4'h7, c);
		end
		rs; lvl = ~img; ce = 0; opcode = 4'h1; instValid = 1;
		repeat (2) @(posedge sys_clk);
		#1 instValid = 0; ce = 1;
		chk({stackError, depth, rungResult}, 8'h00);
		repeat (4) @(posedge sys_clk);
		#1 op(4'h8, ~img[bitAddr]);
		op(4'h9, img[bitAddr]);
		chk(inImage, img);
		op(4'h1, img[bitAddr]);
		useMemBit = 1; memBit = 1;
		op(4'h1, 1'b1);
		useMemBit = 0;
		op(4'ha, 1'b0);
		chk({physOut[bitAddr], outImage[bitAddr]}, 8'h03);
		bitAddr = bitAddr + 3'h1;
		op(4'hb, 1'b0);
		chk({physOut[bitAddr], outImage[bitAddr]}, 8'h01);
		outputPhase = 1;
		@(posedge sys_clk); #1 outputPhase = 0;
		chk(physOut[bitAddr], 8'h01);
		close_out;
	end
endmodule // test_rung_evaluator
